//--- logic/serial_port_top.sv
// logger serial ports: port 1 as RS232 or RS485 master, port 2 as RS232
// or SDI-12 recorder; assumes pins and bus are synchronous to clk_sys
//
// How it works
// - port 2 runs SDI-12 or RS232, never both
// - SDI-12 recorder sends address-led commands
// - SDI-12 fixed at 1200 bit/s
// - start bit, seven data bits lsb first
// - even parity bit, then one stop bit
// - SDI-12 line turns to receive immediately
// - RS232 selectable rates up to 230400
// - port 1 runs RS232 or RS485, never both
// - RS485 master polls; slaves only answer
`timescale 1ns/1ns
`default_nettype none
module serial_port_top #(
	parameter serial_port_pkg::div_t DIV_1200 =
		serial_port_pkg::DIV_W'(serial_port_pkg::CLK_HZ / 1200),
	parameter serial_port_pkg::div_t DIV_9600 =
		serial_port_pkg::DIV_W'(serial_port_pkg::CLK_HZ / 9600),
	parameter serial_port_pkg::div_t DIV_19200 =
		serial_port_pkg::DIV_W'(serial_port_pkg::CLK_HZ / 19200),
	parameter serial_port_pkg::div_t DIV_38400 =
		serial_port_pkg::DIV_W'(serial_port_pkg::CLK_HZ / 38400),
	parameter serial_port_pkg::div_t DIV_57600 =
		serial_port_pkg::DIV_W'(serial_port_pkg::CLK_HZ / 57600),
	parameter logic [serial_port_pkg::TO_W-1:0] REPLY_CYC =
		serial_port_pkg::TO_W'(serial_port_pkg::RS485_REPLY_CYC)
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic [serial_port_pkg::ADDR_W-1:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [31:0] bus_rdata,
	output logic irq,
	output logic p1_232_txd,
	input wire logic p1_232_rxd,
	output logic rs485_txd,
	input wire logic rs485_rxd,
	output logic rs485_de,
	output logic p2_232_txd,
	input wire logic p2_232_rxd,
	input wire logic sdi_in,
	output logic sdi_out,
	output logic sdi_oe
);
	import serial_port_pkg::*;

	// ----------------------------------------------------------------
	// registers and per-port state
	// ----------------------------------------------------------------
	logic [7:0] ctrl_q;
	logic [6:0] sdi_addr_q;
	logic [IRQ_W-1:0] stat_q;
	logic [IRQ_W-1:0] en_q;
	logic [IRQ_W-1:0] evt;
	logic [31:0] rdata_q;
	logic [31:0] rd_mux;
	logic p1_485;
	logic p2_sdi;
	div_t eng_div [2];
	logic eng_sdi [2];
	logic eng_rxd [2];
	logic eng_txd [2];
	logic eng_busy [2];
	logic pend_q [2];
	logic pfx_q [2];
	logic [7:0] pdat_q [2];
	logic rxv_q [2];
	logic [7:0] rxb_q [2];
	logic wr_tx [2];
	logic rd_rx [2];
	logic rx_evt [2];
	logic txd_evt [2];
	logic perr_evt [2];
	logic ferr_evt [2];
	logic ovr_evt [2];
	logic await_q;
	logic heard_q;
	logic [TO_W-1:0] to_cnt_q;
	logic rx1_busy;
	logic unsol_evt;
	logic rto_evt;

	// one mode bit per shared port
	assign p1_485 = ctrl_q[CTRL_P1_485];
	// sdi or rs232 on port 2
	assign p2_sdi = ctrl_q[CTRL_P2_SDI];

	function automatic div_t baud_div(input logic [2:0] s);
		case (s)
			BSEL_9600: return DIV_9600;
			BSEL_19200: return DIV_19200;
			BSEL_38400: return DIV_38400;
			BSEL_57600: return DIV_57600;
			BSEL_115200: return DIV_115200;
			BSEL_230400: return DIV_230400;
			default: return DIV_115200;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// port configuration and pin steering
	// ----------------------------------------------------------------
	always_comb begin
		eng_div[0] = baud_div(ctrl_q[CTRL_P1_BAUD +: 3]);
		eng_div[1] = p2_sdi ? DIV_1200 : baud_div(ctrl_q[CTRL_P2_BAUD +: 3]);
		eng_sdi[0] = 1'b0;
		eng_sdi[1] = p2_sdi;
		// own echo is not a slave reply
		eng_rxd[0] = p1_485 ? (rs485_de | rs485_rxd) : p1_232_rxd;
		eng_rxd[1] = p2_sdi ? (sdi_oe | sdi_in) : p2_232_rxd;
	end

	// drive the bus only while polling
	assign rs485_de = p1_485 & eng_busy[0];
	assign rs485_txd = p1_485 ? eng_txd[0] : 1'b1;
	assign p1_232_txd = p1_485 ? 1'b1 : eng_txd[0];
	// release the line as the stop bit ends
	assign sdi_oe = p2_sdi & (eng_busy[0+1] | pend_q[1]);
	assign sdi_out = p2_sdi ? eng_txd[1] : 1'b1;
	assign p2_232_txd = p2_sdi ? 1'b1 : eng_txd[1];

	// ----------------------------------------------------------------
	// per-port engine, transmit queue and receive holding register
	// ----------------------------------------------------------------
	for (genvar g = 0; g < 2; g++) begin : g_port
		serial_engine_if lnk ();
		logic [ADDR_W-1:0] tx_ofs;
		logic [ADDR_W-1:0] rx_ofs;

		assign tx_ofs = (g == 0) ? OFS_P1_TX : OFS_P2_TX;
		assign rx_ofs = (g == 0) ? OFS_P1_RX : OFS_P2_RX;
		assign wr_tx[g] = bus_wr && bus_addr == tx_ofs;
		assign rd_rx[g] = bus_rd && bus_addr == rx_ofs;
		assign lnk.div = eng_div[g];
		// seven data bits with even parity when the port runs SDI-12, else eight bits and no parity
		assign lnk.bits7 = eng_sdi[g];
		assign lnk.par_en = eng_sdi[g];
		assign lnk.rxd = eng_rxd[g];
		assign lnk.tx_valid = pend_q[g];
		assign lnk.tx_data = pfx_q[g] ? {1'b0, sdi_addr_q} : pdat_q[g];
		assign eng_txd[g] = lnk.txd;
		assign eng_busy[g] = lnk.busy;
		assign rx_evt[g] = lnk.rx_valid;
		assign txd_evt[g] = lnk.tx_done & !pend_q[g];
		assign perr_evt[g] = lnk.rx_valid & lnk.rx_perr;
		assign ferr_evt[g] = lnk.rx_valid & lnk.rx_ferr;
		assign ovr_evt[g] = lnk.rx_valid & rxv_q[g] & !rd_rx[g];

		serial_engine u_eng (
			.clk_sys(clk_sys),
			.rst(rst),
			.ce(ce),
			.lnk(lnk)
		);

		// a write while a character waits is dropped; poll the free bit
		always_ff @(posedge clk_sys) begin
			if (rst) begin
				pend_q[g] <= 1'b0;
				pfx_q[g] <= 1'b0;
				pdat_q[g] <= 8'h00;
			end else if (ce) begin
				if (!pend_q[g] && wr_tx[g]) begin
					pend_q[g] <= 1'b1;
					pdat_q[g] <= bus_wdata[7:0];
					pfx_q[g] <= bus_wdata[TX_PFX_BIT] && eng_sdi[g];
				end else if (pend_q[g] && lnk.tx_ready) begin
					pfx_q[g] <= 1'b0;
					pend_q[g] <= pfx_q[g];
				end
			end
		end

		// a new character wins over the read that frees the holder
		always_ff @(posedge clk_sys) begin
			if (rst) begin
				rxv_q[g] <= 1'b0;
				rxb_q[g] <= 8'h00;
			end else if (ce) begin
				if (lnk.rx_valid) begin
					rxv_q[g] <= 1'b1;
					rxb_q[g] <= lnk.rx_data;
				end else if (rd_rx[g]) begin
					rxv_q[g] <= 1'b0;
				end
			end
		end

		if (g == 0) begin : g_p1
			assign rx1_busy = lnk.rx_busy;
		end
	end

	// ----------------------------------------------------------------
	// rs485 reply window
	// ----------------------------------------------------------------
	// a finished poll opens the window; silence for REPLY_CYC closes it
	// replies only inside the window
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			await_q <= 1'b0;
			heard_q <= 1'b0;
			to_cnt_q <= '0;
		end else if (ce) begin
			if (!p1_485 || rs485_de) begin
				await_q <= 1'b0;
				heard_q <= 1'b0;
				to_cnt_q <= '0;
			end else if (txd_evt[0]) begin
				await_q <= 1'b1;
				heard_q <= 1'b0;
				to_cnt_q <= '0;
			end else if (await_q) begin
				if (rx_evt[0]) begin
					heard_q <= 1'b1;
					to_cnt_q <= '0;
				end else if (rx1_busy) begin
					to_cnt_q <= '0;
				end else if (to_cnt_q == REPLY_CYC - 1'b1) begin
					await_q <= 1'b0;
				end else begin
					to_cnt_q <= to_cnt_q + 1'b1;
				end
			end
		end
	end

	assign unsol_evt = p1_485 & rx_evt[0] & !await_q;
	assign rto_evt = await_q & !heard_q & !rx_evt[0] & !rx1_busy &
		(to_cnt_q == REPLY_CYC - 1'b1);

	// ----------------------------------------------------------------
	// interrupt status
	// ----------------------------------------------------------------
	always_comb begin
		evt = '0;
		evt[IRQ_P1_RX] = rx_evt[0];
		evt[IRQ_P1_TXD] = txd_evt[0];
		evt[IRQ_P2_RX] = rx_evt[1];
		evt[IRQ_P2_TXD] = txd_evt[1];
		evt[IRQ_PERR] = perr_evt[1];
		evt[IRQ_FERR] = ferr_evt[0] | ferr_evt[1];
		evt[IRQ_OVR] = ovr_evt[0] | ovr_evt[1];
		evt[IRQ_UNSOL] = unsol_evt;
		evt[IRQ_RTO] = rto_evt;
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			stat_q <= '0;
		end else if (ce) begin
			if (bus_wr && bus_addr == OFS_IRQ_CLR) begin
				stat_q <= (stat_q & ~bus_wdata[IRQ_W-1:0]) | evt;
			end else begin
				stat_q <= stat_q | evt;
			end
		end
	end

	assign irq = |(stat_q & en_q);

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	// mode changes take effect at once, even mid-character
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_q <= CTRL_RST;
			sdi_addr_q <= SDI_ADDR_RST;
			en_q <= '0;
		end else if (ce && bus_wr) begin
			case (bus_addr)
				OFS_CTRL: ctrl_q <= bus_wdata[7:0];
				OFS_SDI_ADDR: sdi_addr_q <= bus_wdata[6:0];
				OFS_IRQ_EN: en_q <= bus_wdata[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read path, one cycle latency
	// ----------------------------------------------------------------
	always_comb begin
		case (bus_addr)
			OFS_CTRL: rd_mux = 32'(ctrl_q);
			OFS_SDI_ADDR: rd_mux = 32'(sdi_addr_q);
			OFS_P1_TX: rd_mux = 32'(!pend_q[0]);
			OFS_P1_RX: rd_mux = 32'({rxv_q[0], rxb_q[0]});
			OFS_P2_TX: rd_mux = 32'(!pend_q[1]);
			OFS_P2_RX: rd_mux = 32'({rxv_q[1], rxb_q[1]});
			OFS_IRQ_STAT: rd_mux = 32'(stat_q);
			OFS_IRQ_EN: rd_mux = 32'(en_q);
			OFS_STATUS: rd_mux = 32'({await_q, sdi_oe, rs485_de,
				eng_busy[1] | pend_q[1], eng_busy[0] | pend_q[0]});
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata_q <= 32'h0000_0000;
		end else if (ce) begin
			rdata_q <= bus_rd ? rd_mux : 32'h0000_0000;
		end
	end

	assign bus_rdata = rdata_q;

endmodule
`default_nettype wire

//--- logic/serial_port_pkg.sv
// constants shared by the serial port top and its character engine
// assumes a single system clock at CLK_HZ; all rates derive from it
package serial_port_pkg;

	// ----------------------------------------------------------------
	// clock and line rates
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned SDI12_BAUD = 1200;
	localparam int unsigned BAUD_9600 = 9600;
	localparam int unsigned BAUD_19200 = 19200;
	localparam int unsigned BAUD_38400 = 38400;
	localparam int unsigned BAUD_57600 = 57600;
	localparam int unsigned BAUD_115200 = 115200;
	localparam int unsigned BAUD_230400 = 230400;
	localparam int DIV_W = 18;
	typedef logic [DIV_W-1:0] div_t;
	localparam div_t DIV_115200 = DIV_W'(CLK_HZ / BAUD_115200);
	localparam div_t DIV_230400 = DIV_W'(CLK_HZ / BAUD_230400);
	// silence after a poll before the master gives up on a reply
	localparam int unsigned RS485_REPLY_US = 1000;
	localparam int unsigned RS485_REPLY_CYC =
		(CLK_HZ / 1_000_000) * RS485_REPLY_US;
	localparam int TO_W = 20;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 6;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_SDI_ADDR = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_P1_TX = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_P1_RX = 6'h0C;
	localparam logic [ADDR_W-1:0] OFS_P2_TX = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_P2_RX = 6'h14;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 6'h18;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 6'h1C;
	localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 6'h20;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h24;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_P1_485 = 0;
	localparam int CTRL_P2_SDI = 1;
	localparam int CTRL_P1_BAUD = 2;
	localparam int CTRL_P2_BAUD = 5;
	localparam logic [7:0] CTRL_RST = 8'h90;
	localparam logic [6:0] SDI_ADDR_RST = 7'h30;
	localparam logic [2:0] BSEL_9600 = 3'h0;
	localparam logic [2:0] BSEL_19200 = 3'h1;
	localparam logic [2:0] BSEL_38400 = 3'h2;
	localparam logic [2:0] BSEL_57600 = 3'h3;
	localparam logic [2:0] BSEL_115200 = 3'h4;
	localparam logic [2:0] BSEL_230400 = 3'h5;
	localparam int TX_PFX_BIT = 8;
	localparam int IRQ_P1_RX = 0;
	localparam int IRQ_P1_TXD = 1;
	localparam int IRQ_P2_RX = 2;
	localparam int IRQ_P2_TXD = 3;
	localparam int IRQ_PERR = 4;
	localparam int IRQ_FERR = 5;
	localparam int IRQ_OVR = 6;
	localparam int IRQ_UNSOL = 7;
	localparam int IRQ_RTO = 8;
	localparam int IRQ_W = 9;

endpackage

//--- logic/serial_engine_if.sv
// control and data bundle between the port top and one character engine
// assumes both ends sit on clk_sys
`timescale 1ns/1ns
`default_nettype none
interface serial_engine_if;
	import serial_port_pkg::*;
	div_t div;
	logic bits7;
	logic par_en;
	logic tx_valid;
	logic [7:0] tx_data;
	logic tx_ready;
	logic tx_done;
	logic busy;
	logic txd;
	logic rxd;
	logic rx_busy;
	logic rx_valid;
	logic [7:0] rx_data;
	logic rx_perr;
	logic rx_ferr;
	modport eng(input div, bits7, par_en, tx_valid, tx_data, rxd,
		output tx_ready, tx_done, busy, txd, rx_busy, rx_valid,
		rx_data, rx_perr, rx_ferr);
	modport ctl(output div, bits7, par_en, tx_valid, tx_data, rxd,
		input tx_ready, tx_done, busy, txd, rx_busy, rx_valid,
		rx_data, rx_perr, rx_ferr);
endinterface
`default_nettype wire

//--- logic/serial_engine.sv
// one async character engine: start, 7 or 8 data lsb first,
// optional even parity, one stop; assumes rxd is synchronous to clk_sys
`timescale 1ns/1ns
`default_nettype none
module serial_engine (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	serial_engine_if.eng lnk
);
	import serial_port_pkg::*;

	typedef enum {RX_IDLE, RX_BITS} rx_state_e;

	logic [3:0] nbits;
	logic [3:0] flen;
	logic [10:0] tx_sh_q;
	logic [3:0] tx_left_q;
	div_t tx_cnt_q;
	logic tx_done_q;
	rx_state_e rx_st_q;
	logic rx_prev_q;
	logic [3:0] rx_idx_q;
	div_t rx_cnt_q;
	logic [10:0] rx_fr_q;
	logic [10:0] rx_fr;
	logic [7:0] rx_d;
	logic rx_p;
	logic rx_valid_q;
	logic [7:0] rx_data_q;
	logic rx_perr_q;
	logic rx_ferr_q;

	assign nbits = lnk.bits7 ? 4'h7 : 4'h8;
	assign flen = nbits + {3'h0, lnk.par_en} + 4'h2;

	function automatic logic [10:0] build(input logic [7:0] d,
		input logic [3:0] n, input logic pe);
		logic [10:0] f;
		logic p;
		f = '1;
		f[0] = 1'b0;
		p = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (i < int'(n)) begin
				f[i+1] = d[i];
				p = p ^ d[i];
			end
		end
		if (pe) begin
			f[n + 4'h1] = p;
		end
		return f;
	endfunction

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	// frame then shift lsb first
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tx_sh_q <= '1;
			tx_left_q <= 4'h0;
			tx_cnt_q <= '0;
			tx_done_q <= 1'b0;
		end else if (ce) begin
			tx_done_q <= 1'b0;
			if (tx_left_q == 4'h0) begin
				if (lnk.tx_valid) begin
					tx_sh_q <= build(lnk.tx_data, nbits, lnk.par_en);
					tx_left_q <= flen;
					tx_cnt_q <= lnk.div - 1'b1;
				end
			end else if (tx_cnt_q == '0) begin
				tx_sh_q <= {1'b1, tx_sh_q[10:1]};
				tx_left_q <= tx_left_q - 4'h1;
				tx_cnt_q <= lnk.div - 1'b1;
				tx_done_q <= (tx_left_q == 4'h1);
			end else begin
				tx_cnt_q <= tx_cnt_q - 1'b1;
			end
		end
	end

	// idle shifts in ones, so the line rests at mark
	assign lnk.txd = tx_sh_q[0];
	assign lnk.tx_ready = (tx_left_q == 4'h0);
	assign lnk.busy = (tx_left_q != 4'h0);
	assign lnk.tx_done = tx_done_q;

	// ----------------------------------------------------------------
	// receiver
	// ----------------------------------------------------------------
	always_comb begin
		rx_fr = rx_fr_q;
		rx_fr[rx_idx_q] = lnk.rxd;
		rx_d = 8'h00;
		rx_p = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (i < int'(nbits)) begin
				rx_d[i] = rx_fr[i+1];
				rx_p = rx_p ^ rx_fr[i+1];
			end
		end
	end

	// mid-bit sampling: half a bit after the falling edge, then whole bits
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rx_st_q <= RX_IDLE;
			rx_prev_q <= 1'b1;
			rx_idx_q <= 4'h0;
			rx_cnt_q <= '0;
			rx_fr_q <= '1;
			rx_valid_q <= 1'b0;
			rx_data_q <= 8'h00;
			rx_perr_q <= 1'b0;
			rx_ferr_q <= 1'b0;
		end else if (ce) begin
			rx_prev_q <= lnk.rxd;
			rx_valid_q <= 1'b0;
			case (rx_st_q)
				RX_IDLE: begin
					if (rx_prev_q && !lnk.rxd) begin
						rx_st_q <= RX_BITS;
						rx_idx_q <= 4'h0;
						rx_cnt_q <= lnk.div >> 1;
					end
				end
				RX_BITS: begin
					if (rx_cnt_q != '0) begin
						rx_cnt_q <= rx_cnt_q - 1'b1;
					end else begin
						rx_fr_q <= rx_fr;
						rx_cnt_q <= lnk.div - 1'b1;
						rx_idx_q <= rx_idx_q + 4'h1;
						if (rx_idx_q == 4'h0 && lnk.rxd) begin
							rx_st_q <= RX_IDLE;
						end else if (rx_idx_q == flen - 4'h1) begin
							rx_st_q <= RX_IDLE;
							rx_valid_q <= 1'b1;
							rx_data_q <= rx_d;
							rx_perr_q <= lnk.par_en &&
								(rx_p != rx_fr[nbits + 4'h1]);
							rx_ferr_q <= !lnk.rxd;
						end
					end
				end
				default: rx_st_q <= RX_IDLE;
			endcase
		end
	end

	assign lnk.rx_busy = (rx_st_q == RX_BITS);
	assign lnk.rx_valid = rx_valid_q;
	assign lnk.rx_data = rx_data_q;
	assign lnk.rx_perr = rx_perr_q;
	assign lnk.rx_ferr = rx_ferr_q;

endmodule
`default_nettype wire

//--- testbench/serial_port_properties.sv
// line timing checker for serial_port_top, bound to its ports
// assumes one clock domain on clk_sys, rst synchronous active high
`timescale 1ns/1ns
`default_nettype none
module serial_port_properties #(
	parameter serial_port_pkg::div_t DIV_1200 = 18'h00010
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic p1_232_txd,
	input wire logic rs485_txd,
	input wire logic rs485_de,
	input wire logic p2_232_txd,
	input wire logic sdi_out,
	input wire logic sdi_oe
);
	import serial_port_pkg::*;
	logic last_q;
	int run_q;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// length of the level run on the sdi drive, ending last cycle
	always_ff @(posedge clk_sys) begin
		last_q <= sdi_out;
		if (rst || sdi_out != last_q) begin
			run_q <= 1;
		end else begin
			run_q <= run_q + 1;
		end
	end
	AST_P2_EXCL: assert property (sdi_oe |-> p2_232_txd)
		else $error("port 2 rs232 active while sdi drives");
	AST_P1_EXCL: assert property (rs485_de |-> p1_232_txd)
		else $error("port 1 rs232 active while rs485 drives");
	AST_SDI_IDLE: assert property (!sdi_oe |-> sdi_out)
		else $error("sdi drive level not idle while released");
	AST_SDI_START: assert property ($rose(sdi_oe) |=> sdi_oe && !sdi_out)
		else $error("sdi start bit missing after enable");
	AST_SDI_BIT: assert property (sdi_oe && $past(sdi_oe) && sdi_out && !last_q
		|-> run_q % int'(DIV_1200) == 0)
		else $error("sdi low run not a whole number of bits");
	AST_SDI_STOP: assert property ($fell(sdi_oe) |-> $past(sdi_out))
		else $error("sdi released without stop bit");
	AST_SDI_TURN: assert property ($fell(sdi_oe)
		|-> run_q % int'(DIV_1200) == 0)
		else $error("sdi turnaround not at end of stop bit");
	AST_DE_START: assert property ($rose(rs485_de) |-> ##[0:1] !rs485_txd)
		else $error("rs485 enable without start bit");
	AST_DE_IDLE: assert property (!rs485_de |-> rs485_txd)
		else $error("rs485 data not idle while driver off");
endmodule
bind serial_port_top serial_port_properties #(.DIV_1200(DIV_1200))
	serial_port_properties_inst (.clk_sys(clk_sys), .rst(rst),
	.p1_232_txd(p1_232_txd), .rs485_txd(rs485_txd), .rs485_de(rs485_de),
	.p2_232_txd(p2_232_txd), .sdi_out(sdi_out), .sdi_oe(sdi_oe));
`default_nettype wire

//--- testbench/serial_sensor_model.sv
// far side: sdi sensor, rs485 slave, rs232 loopback on both ports
// assumes logic levels, idle 1; released lines are pulled to idle
`timescale 1ns/1ns
`default_nettype none
module serial_sensor_model #(
	parameter int SDI_BT = 16,
	parameter int RS_BT = 8,
	parameter logic [7:0] SLAVE_ADDR = 8'h05
) (
	input wire logic clk_sys,
	input wire logic bad_par,
	input wire logic sdi_out,
	input wire logic sdi_oe,
	output logic sdi_in,
	input wire logic rs485_txd,
	input wire logic rs485_de,
	output logic rs485_rxd,
	input wire logic p1_232_txd,
	output logic p1_232_rxd,
	input wire logic p2_232_txd,
	output logic p2_232_rxd
);
	logic sdi_drv = 1'b1;
	logic rs_drv = 1'b1;
	logic [9:0] sdi_seen[$];
	int p1_bt = 0;
	assign sdi_in = sdi_oe ? sdi_out : sdi_drv;
	assign rs485_rxd = rs485_de ? rs485_txd : rs_drv;
	assign p1_232_rxd = p1_232_txd;
	assign p2_232_rxd = p2_232_txd;
	// sample a frame from mid start bit on
	task automatic grab(input int bt, input bit s, output logic [9:0] f);
		repeat (bt / 2) @(posedge clk_sys);
		for (int i = 0; i < 10; i++) begin
			f[i] = s ? sdi_out : rs485_txd;
			if (i < 9) repeat (bt) @(posedge clk_sys);
		end
	endtask
	// ends on the stop bit, so the line is left at idle
	task automatic send(input int bt, input bit s, input logic [9:0] f);
		for (int i = 0; i < 10; i++) begin
			if (s)
				sdi_drv <= f[i];
			else
				rs_drv <= f[i];
			repeat (bt) @(posedge clk_sys);
		end
	endtask
	always begin : sdi_sensor
		logic [9:0] f;
		@(posedge clk_sys);
		if (sdi_oe && !sdi_out) begin
			grab(SDI_BT, 1'b1, f);
			sdi_seen.push_back(f);
			while (sdi_oe && sdi_out) @(posedge clk_sys);
			// prompt reply: a late turnaround loses its start bit
			if (!sdi_oe) send(SDI_BT, 1'b1, {1'b1, ^7'h30 ^ bad_par, 7'h30, 1'b0});
		end
	end
	always begin : rs485_slave
		logic [9:0] f;
		@(posedge clk_sys);
		if (rs485_de && !rs485_txd) begin
			grab(RS_BT, 1'b0, f);
			while (rs485_de) @(posedge clk_sys);
			if (f[8:1] == SLAVE_ADDR) send(RS_BT, 1'b0, {1'b1, 8'hA5, 1'b0});
		end
	end
	always begin : p1_meas
		int n;
		@(negedge p1_232_txd);
		n = 0;
		@(negedge clk_sys);
		while (!p1_232_txd) begin
			n++;
			@(negedge clk_sys);
		end
		p1_bt = n;
	end
endmodule
`default_nettype wire

//--- testbench/serial_port_top_tb.sv
// self-checking bench: register tasks drive serial_port_top
// assumes the sensor model on every line and shortened bit times
`timescale 1ns/1ns
`default_nettype none
module serial_port_top_tb;
	import serial_port_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic [ADDR_W-1:0] bus_addr = '0;
	logic [31:0] bus_wdata = '0;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic bad_par = 1'b0;
	logic [31:0] bus_rdata;
	logic irq, p1_232_txd, p1_232_rxd, rs485_txd, rs485_rxd, rs485_de;
	logic p2_232_txd, p2_232_rxd, sdi_in, sdi_out, sdi_oe;
	int err_count = 0;
	int checks_done = 0;
	always #2 clk_sys = ~clk_sys;
	serial_port_top #(.DIV_1200(18'h00010), .DIV_9600(18'h00008),
		.DIV_19200(18'h0000A), .DIV_38400(18'h0000C), .DIV_57600(18'h0000E),
		.REPLY_CYC(20'h000C8)) serial_port_top_inst (.clk_sys(clk_sys),
		.rst(rst), .ce(ce), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq),
		.p1_232_txd(p1_232_txd), .p1_232_rxd(p1_232_rxd),
		.rs485_txd(rs485_txd), .rs485_rxd(rs485_rxd), .rs485_de(rs485_de),
		.p2_232_txd(p2_232_txd), .p2_232_rxd(p2_232_rxd), .sdi_in(sdi_in),
		.sdi_out(sdi_out), .sdi_oe(sdi_oe));
	serial_sensor_model serial_sensor_model_inst (.clk_sys(clk_sys),
		.bad_par(bad_par), .sdi_out(sdi_out), .sdi_oe(sdi_oe),
		.sdi_in(sdi_in), .rs485_txd(rs485_txd), .rs485_de(rs485_de),
		.rs485_rxd(rs485_rxd), .p1_232_txd(p1_232_txd),
		.p1_232_rxd(p1_232_rxd), .p2_232_txd(p2_232_txd),
		.p2_232_rxd(p2_232_rxd));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks=%0d errors=%0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// the idle edge at the end keeps strobes from being set twice at once
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clk_sys);
		bus_wr <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clk_sys);
		bus_rd <= 1'b0;
		#1 chk(bus_rdata, exp);
		@(posedge clk_sys);
	endtask
	task automatic wait_irq(input int lim);
		int n = 0;
		while (irq !== 1'b1 && n < lim) begin
			@(posedge clk_sys);
			n++;
		end
		if (irq !== 1'b1) begin
			err_count++;
			$display("ERROR t=%0t irq wait ran out", $time);
			test_done();
		end
	endtask
	task automatic chk_frame(input int k, input logic [6:0] c);
		chk(32'(serial_sensor_model_inst.sdi_seen[k]), {22'h0, 1'b1, ^c, c, 1'b0});
	endtask
	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin : main
		int divs[5];
		divs = '{8, 10, 12, 14, int'(DIV_115200)};
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		rd(OFS_CTRL, 32'h00000090);
		rd(OFS_SDI_ADDR, 32'h00000030);
		rd(6'h3C, 32'h00000000);
		// a write while the clock enable is low must leave no trace
		ce <= 1'b0;
		wr(OFS_SDI_ADDR, 32'h00000055);
		ce <= 1'b1;
		rd(OFS_SDI_ADDR, 32'h00000030);
		wr(OFS_CTRL, 32'h00000003);
		wr(OFS_SDI_ADDR, 32'h00000031);
		wr(OFS_IRQ_EN, 32'h00000004);
		wr(OFS_P2_TX, 32'h0000014D);
		wait_irq(2000);
		chk_frame(0, 7'h31);
		chk_frame(1, 7'h4D);
		rd(OFS_P2_RX, 32'h00000130);
		rd(OFS_IRQ_STAT, 32'h0000000C);
		wr(OFS_IRQ_CLR, 32'h000001FF);
		bad_par <= 1'b1;
		wr(OFS_P2_TX, 32'h00000021);
		wait_irq(2000);
		chk_frame(2, 7'h21);
		rd(OFS_IRQ_STAT, 32'h0000001C);
		wr(OFS_IRQ_EN, 32'h00000000);
		chk(32'(irq), 32'h00000000);
		wr(OFS_IRQ_CLR, 32'h000001FF);
		wr(OFS_IRQ_EN, 32'h00000001);
		wr(OFS_P1_TX, 32'h00000005);
		wait_irq(1000);
		rd(OFS_P1_RX, 32'h000001A5);
		rd(OFS_IRQ_STAT, 32'h00000003);
		// let the reply window run out before the next poll
		repeat (300) @(posedge clk_sys);
		wr(OFS_IRQ_CLR, 32'h000001FF);
		wr(OFS_IRQ_EN, 32'h00000100);
		wr(OFS_P1_TX, 32'h00000007);
		wait_irq(1000);
		rd(OFS_IRQ_STAT, 32'h00000102);
		wr(OFS_IRQ_EN, 32'h00000001);
		for (int b = 0; b < 5; b++) begin
			wr(OFS_IRQ_CLR, 32'h000001FF);
			wr(OFS_CTRL, 32'(b << 2) | 32'h00000002);
			wr(OFS_P1_TX, 32'h00000055);
			wait_irq(25000);
			rd(OFS_P1_RX, 32'h00000155);
			chk(32'(serial_sensor_model_inst.p1_bt), 32'(divs[b]));
		end
		test_done();
	end
endmodule
`default_nettype wire
